// ### hdl/cts_top.v
// Camera trigger, exposure window, address restore and status LED logic with AHB-Lite registers
`include "cts_regs.vh"

// Overview of the block
// Trigger pin, exposure window, address restore and status LED of the camera
// All logic runs on hclk, frozen while clk_en is low
// Bus is frozen with it, so keep clk_en high during register access
//
// Register map, one aligned word each
// 0x00 control: slave mode, edge select, exposure polarity,
//      link up, firmware upgrade, driver upgrade, software trigger
// 0x04 status: exposing, restored, self reset, dropped trigger
// 0x08 exposure length in cycles, zero written becomes one
// 0x0C current network address, read and write
// Unmapped offsets read zero and ignore writes
//
// Bus timing
// Zero wait states, response always OKAY
// Address phase taken at the edge with hsel, hready and htrans[1]
// Read data registered at that edge, stands until the next read
// Write data taken from hwdata one edge later
// Software trigger bit acts on that write outside slave mode only and reads back zero
//
// Trigger path
// Pin passes two flip-flops before edge detection, the third holds the old level
// Edge is seen two edges after the pin moves
// Start pulse and exposure output follow one edge after detection
// Edges during an exposure are dropped and flagged
// Pin edges outside slave mode are ignored
// Pulses shorter than one cycle may be missed
//
// Exposure window
// Output stands active for exactly the programmed length
// Active low unless the polarity bit is set
// Changing polarity while idle moves the pin without a start
//
// Restore input
// Synchronised level counted every cycle while high
// Any drop clears the count, so bounce restarts the hold
// At the restore time the default address is loaded
// Restored flag is sticky, write one to clear, set wins
// On the button variant the LED goes dark while held past it
//
// Purple sequence
// Release between press time and restore time starts it
// Steady purple, then two off and on blinks
// Ends with a one-cycle self reset pulse
// Self reset pulse is for the system, this block keeps running
//
// LED priority, highest first
// Button held dark, purple sequence, firmware white,
// driver green blink, link blue steady, blue blink
// Blink timebase runs free, so the first blink may be short
//
// Hazards and limits
// Cycle counters are 32 bits; the restore time must fit below 2^31
// Parameters are in cycles of hclk, not in time
// Scaled values keep simulation short
// Status exposing bit follows the internal flag, not the pin
// A start and its exposure pulse leave the same edge
// Dropped flag set wins over a clear in the same cycle
// No interrupt; software polls the status word
// Identity values are not part of this block
// Synchroniser first stage read only by the second stage
// Reset branches load constants only
// Outputs all come from flip-flops
// Link state is set by software, not sensed here
// Upgrade states are set and cleared by software
// Address restore does not touch the control word

module cts_top #(
    parameter BLINK_CYC   = `CTS_BLINK_CYC,    // Half blink period in cycles
    parameter RESTORE_CYC = `CTS_RESTORE_CYC,  // Hold time for address restore
    parameter PRESS_CYC   = `CTS_PRESS_CYC,    // Press time for self reset path
    parameter PURPLE_CYC  = `CTS_PURPLE_CYC,   // Purple steady phase length
    parameter BUTTON_VAR  = 1'b0               // High on button variant
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        ext_trigger_in,
    input  wire        address_restore_in,
    output reg         exposure_out,
    output reg         acq_start,
    output reg  [2:0]  led_rgb,
    output reg         self_reset,
    output reg  [31:0] ip_addr
);

    // Bus capture of a write address phase
    reg        wr_pend_reg;
    reg [7:0]  wr_addr_reg;
    // Software registers
    reg [31:0] ctrl_reg;
    reg [31:0] expo_len_reg;
    reg        restored_reg;
    reg        dropped_reg;
    // Synchronisers, three stages each
    reg [2:0]  trig_sync_reg;
    reg [2:0]  rst_sync_reg;
    // Exposure state
    reg        exposing_reg;
    reg [31:0] expo_cnt_reg;
    // Restore input hold counter
    reg [31:0] hold_cnt_reg;
    reg        restore_done_reg;
    // Purple sequence state
    reg [1:0]  pur_state_reg;
    reg [31:0] pur_cnt_reg;
    reg [1:0]  pur_blinks_reg;
    // Blink timebase
    reg [31:0] blink_cnt_reg;
    reg        blink_phase_reg;

    localparam PUR_IDLE  = 2'h0;  // No sequence
    localparam PUR_ON    = 2'h1;  // Steady purple
    localparam PUR_BLINK = 2'h2;  // Two blinks
    localparam PUR_DONE  = 2'h3;  // Self reset issued

    wire       bus_req   = hsel & hready & htrans[1];
    wire       trig_rise = trig_sync_reg[1] & ~trig_sync_reg[2];
    wire       trig_fall = ~trig_sync_reg[1] & trig_sync_reg[2];
    wire       rst_level = rst_sync_reg[1] & rst_sync_reg[2];
    // Selected edge: rising by default, falling when configured
    wire       trig_edge = ctrl_reg[`CTS_CTRL_FALLING] ? trig_fall : trig_rise;
    // Pin trigger counts in slave mode only; software trigger otherwise
    wire       pin_trig  = ctrl_reg[`CTS_CTRL_SLAVE] & trig_edge;
    wire       sw_trig   = wr_pend_reg & (wr_addr_reg == `CTS_CTRL_OFF) &
                           ~ctrl_reg[`CTS_CTRL_SLAVE] & hwdata[`CTS_CTRL_SW_TRIG];
    wire       start_acq = (pin_trig | sw_trig) & ~exposing_reg;

    // Word readback mux
    function [31:0] rd_mux;
        input [7:0] a;
        begin
            case (a)
                `CTS_CTRL_OFF:   rd_mux = ctrl_reg;
                `CTS_STATUS_OFF: rd_mux = {28'h0, dropped_reg, self_reset, restored_reg, exposing_reg};
                `CTS_EXPO_OFF:   rd_mux = expo_len_reg;
                `CTS_IPADDR_OFF: rd_mux = ip_addr;
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // Bus slave: zero wait states, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else if (clk_en) begin
            wr_pend_reg <= bus_req & hwrite;
            if (bus_req) begin
                wr_addr_reg <= {haddr[7:2], 2'b00};
            end
            if (bus_req & ~hwrite) begin
                hrdata <= rd_mux({haddr[7:2], 2'b00});
            end
        end
    end

    // Software registers and sticky status
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg     <= `CTS_CTRL_RESET;
            expo_len_reg <= `CTS_EXPO_RESET;
            restored_reg <= 1'b0;
            dropped_reg  <= 1'b0;
        end else if (clk_en) begin
            if (wr_pend_reg && wr_addr_reg == `CTS_CTRL_OFF) begin
                // Software trigger bit self clears
                ctrl_reg <= {25'h0, 1'b0, hwdata[5:0]};
            end
            if (wr_pend_reg && wr_addr_reg == `CTS_EXPO_OFF) begin
                expo_len_reg <= (hwdata == 32'h0) ? 32'h0000_0001 : hwdata;
            end
            // Write one to clear, set wins
            if (restore_done_reg) begin
                restored_reg <= 1'b1;
            end else if (wr_pend_reg && wr_addr_reg == `CTS_STATUS_OFF && hwdata[`CTS_ST_RESTORED]) begin
                restored_reg <= 1'b0;
            end
            if ((pin_trig | sw_trig) & exposing_reg) begin
                dropped_reg <= 1'b1;
            end else if (wr_pend_reg && wr_addr_reg == `CTS_STATUS_OFF && hwdata[`CTS_ST_DROPPED]) begin
                dropped_reg <= 1'b0;
            end
        end
    end

    // Input synchronisers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_sync_reg <= 3'h0;
            rst_sync_reg  <= 3'h0;
        end else if (clk_en) begin
            trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger_in};
            rst_sync_reg  <= {rst_sync_reg[1:0], address_restore_in};
        end
    end

    // Exposure window per acquisition
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exposing_reg <= 1'b0;
            expo_cnt_reg <= 32'h0000_0000;
            acq_start    <= 1'b0;
            exposure_out <= 1'b1;
        end else if (clk_en) begin
            acq_start <= start_acq;
            if (start_acq) begin
                exposing_reg <= 1'b1;
                expo_cnt_reg <= expo_len_reg - 32'h0000_0001;
            end else if (exposing_reg) begin
                if (expo_cnt_reg == 32'h0) begin
                    exposing_reg <= 1'b0;
                end else begin
                    expo_cnt_reg <= expo_cnt_reg - 32'h0000_0001;
                end
            end
            // Low marks exposure unless inverted
            exposure_out <= ((start_acq | (exposing_reg & (expo_cnt_reg != 32'h0))) ^
                             ~ctrl_reg[`CTS_CTRL_EXPO_HIGH]);
        end
    end

    // Restore input hold timing and address restore
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt_reg     <= 32'h0000_0000;
            restore_done_reg <= 1'b0;
            ip_addr          <= `CTS_IP_DEFAULT;
        end else if (clk_en) begin
            restore_done_reg <= 1'b0;
            if (wr_pend_reg && wr_addr_reg == `CTS_IPADDR_OFF) begin
                ip_addr <= hwdata;
            end
            if (!rst_level) begin
                hold_cnt_reg <= 32'h0000_0000;
            end else if (hold_cnt_reg != 32'hFFFF_FFFF) begin
                hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
            end
            if (rst_level && hold_cnt_reg == RESTORE_CYC - 1) begin
                ip_addr          <= `CTS_IP_DEFAULT;
                restore_done_reg <= 1'b1;
            end
        end
    end

    // Purple sequence after short press, released before restore
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pur_state_reg  <= PUR_IDLE;
            pur_cnt_reg    <= 32'h0000_0000;
            pur_blinks_reg <= 2'h0;
            self_reset     <= 1'b0;
        end else if (clk_en) begin
            case (pur_state_reg)
                PUR_IDLE: begin
                    self_reset <= 1'b0;
                    if (!rst_level && hold_cnt_reg >= PRESS_CYC && hold_cnt_reg < RESTORE_CYC) begin
                        pur_state_reg <= PUR_ON;
                        pur_cnt_reg   <= 32'h0000_0000;
                    end
                end
                PUR_ON: begin
                    if (pur_cnt_reg == PURPLE_CYC - 1) begin
                        pur_state_reg  <= PUR_BLINK;
                        pur_cnt_reg    <= 32'h0000_0000;
                        pur_blinks_reg <= 2'h0;
                    end else begin
                        pur_cnt_reg <= pur_cnt_reg + 32'h0000_0001;
                    end
                end
                PUR_BLINK: begin
                    // Each blink is one off and one on half period
                    if (pur_cnt_reg == 2 * BLINK_CYC - 1) begin
                        pur_cnt_reg    <= 32'h0000_0000;
                        pur_blinks_reg <= pur_blinks_reg + 2'h1;
                        if (pur_blinks_reg == 2'h1) begin
                            pur_state_reg <= PUR_DONE;
                        end
                    end else begin
                        pur_cnt_reg <= pur_cnt_reg + 32'h0000_0001;
                    end
                end
                PUR_DONE: begin
                    self_reset    <= 1'b1;
                    pur_state_reg <= PUR_IDLE;
                end
                default: begin
                    pur_state_reg <= PUR_IDLE;
                end
            endcase
        end
    end

    // Free blink timebase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_cnt_reg   <= 32'h0000_0000;
            blink_phase_reg <= 1'b1;
        end else if (clk_en) begin
            if (blink_cnt_reg == BLINK_CYC - 1) begin
                blink_cnt_reg   <= 32'h0000_0000;
                blink_phase_reg <= ~blink_phase_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // LED colour priority: reset sequences, upgrades, link
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_rgb <= `CTS_LED_OFF;
        end else if (clk_en) begin
            if (BUTTON_VAR && rst_level && hold_cnt_reg >= RESTORE_CYC - 1) begin
                led_rgb <= `CTS_LED_OFF;
            end else if (pur_state_reg == PUR_ON) begin
                led_rgb <= `CTS_LED_PURPLE;
            end else if (pur_state_reg == PUR_BLINK) begin
                led_rgb <= (pur_cnt_reg < BLINK_CYC) ? `CTS_LED_OFF : `CTS_LED_PURPLE;
            end else if (ctrl_reg[`CTS_CTRL_FW_UPG]) begin
                led_rgb <= `CTS_LED_WHITE;
            end else if (ctrl_reg[`CTS_CTRL_DRV_UPG]) begin
                led_rgb <= blink_phase_reg ? `CTS_LED_GREEN : `CTS_LED_OFF;
            end else if (ctrl_reg[`CTS_CTRL_LINK_UP]) begin
                led_rgb <= `CTS_LED_BLUE;
            end else begin
                led_rgb <= blink_phase_reg ? `CTS_LED_BLUE : `CTS_LED_OFF;
            end
        end
    end

endmodule

// ### hdl/cts_regs.vh
// Constants of the camera trigger and status logic: offsets, fields, resets, timing
// Notes on behaviour
// - External trigger honoured only in slave mode
// - Valid trigger starts one frame acquisition
// - Trigger recognised on rising edge by default
// - Exposure output asserted for whole exposure
// - Exposure output active low by default
// - Restore input high 10s restores address
// - Button held 10s: LED off, restore
// - Unconnected broadcast: blue LED blinks
// - Connected: blue LED steadily on
// - 5s press: purple 5s, two blinks, reset
// - Firmware upgrade: white LED until finished
// - Driver upgrade: green LED blinks
`ifndef CTS_REGS_VH
`define CTS_REGS_VH
// Register byte offsets
`define CTS_CTRL_OFF        8'h00
`define CTS_STATUS_OFF      8'h04
`define CTS_EXPO_OFF        8'h08
`define CTS_IPADDR_OFF      8'h0C
// Control fields
`define CTS_CTRL_SLAVE      0
`define CTS_CTRL_FALLING    1
`define CTS_CTRL_EXPO_HIGH  2
`define CTS_CTRL_LINK_UP    3
`define CTS_CTRL_FW_UPG     4
`define CTS_CTRL_DRV_UPG    5
`define CTS_CTRL_SW_TRIG    6
`define CTS_CTRL_RESET      32'h0000_0001
// Status fields
`define CTS_ST_EXPOSING     0
`define CTS_ST_RESTORED     1
`define CTS_ST_SELF_RESET   2
`define CTS_ST_DROPPED      3
// Default exposure length in cycles and factory address
`define CTS_EXPO_RESET      32'h0001_E848
`define CTS_IP_DEFAULT      32'hC0A8_0165
// Timing figures
`define CTS_CLK_MHZ         125
`define CTS_BLINK_MS        500
`define CTS_RESTORE_MS      10000
`define CTS_PRESS_MS        5000
`define CTS_PURPLE_MS       5000
`define CTS_MS_CYCLES       (`CTS_CLK_MHZ * 1000)
`define CTS_BLINK_CYC       (`CTS_BLINK_MS * `CTS_MS_CYCLES)
`define CTS_RESTORE_CYC     (`CTS_RESTORE_MS * `CTS_MS_CYCLES)
`define CTS_PRESS_CYC       (`CTS_PRESS_MS * `CTS_MS_CYCLES)
`define CTS_PURPLE_CYC      (`CTS_PURPLE_MS * `CTS_MS_CYCLES)
// LED colour codes {red, green, blue}
`define CTS_LED_OFF         3'h0
`define CTS_LED_BLUE        3'h1
`define CTS_LED_GREEN       3'h2
`define CTS_LED_PURPLE      3'h5
`define CTS_LED_WHITE       3'h7
`endif

// ### sim/cts_props.sv
// Checker of bus answer, trigger, exposure, restore and LED relations
`include "cts_regs.vh"
module cts_props (
    input logic        hclk,
    input logic        hresetn,
    input logic        hreadyout,
    input logic        hresp,
    input logic        address_restore_in,
    input logic        exposure_out,
    input logic        acq_start,
    input logic [2:0]  led_rgb,
    input logic        self_reset,
    input logic [31:0] ip_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Zero-wait OKAY answer at all times
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not OKAY");
    start_pulse_a: assert property (acq_start |=> !acq_start)
        else $error("start pulse longer than one cycle");
    expo_start_a: assert property (acq_start |-> !exposure_out)
        else $error("exposure not low with start");
    expo_cause_a: assert property ($fell(exposure_out) |-> acq_start)
        else $error("exposure began without a start");
    idle_start_a: assert property (acq_start |-> $past(exposure_out))
        else $error("start while exposing");
    restore_hold_a: assert property ($changed(ip_addr) && ip_addr == `CTS_IP_DEFAULT
        |-> $past(address_restore_in, 3)) else $error("address restored without hold");
    self_pulse_a: assert property (self_reset |=> !self_reset)
        else $error("self reset longer than one cycle");
    led_code_a: assert property (led_rgb inside {`CTS_LED_OFF, `CTS_LED_BLUE,
        `CTS_LED_GREEN, `CTS_LED_PURPLE, `CTS_LED_WHITE}) else $error("illegal LED colour");
    // Main scenarios reached
    cover property (acq_start);
    cover property ($changed(ip_addr) && ip_addr == `CTS_IP_DEFAULT);
    cover property (self_reset);
endmodule

bind cts_top cts_props chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .address_restore_in(address_restore_in), .exposure_out(exposure_out),
    .acq_start(acq_start), .led_rgb(led_rgb), .self_reset(self_reset), .ip_addr(ip_addr));

// ### sim/cts_trig_src.sv
// Trigger source and restore button model at the camera pins
module cts_trig_src #(
    parameter int PW = 50  // Pulse width in cycles, scaled down
) (
    input  logic hclk,
    output logic trig_out,
    output logic restore_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both lines rest low between uses
    initial begin
        trig_out = 1'b0;
        restore_out = 1'b0;
    end
    // One clean pulse, no bounce, fixed width
    task automatic pulse();
        trig_out <= 1'b1;
        repeat (PW) @(posedge hclk);
        trig_out <= 1'b0;
        @(posedge hclk);
    endtask
    // Press held for n cycles, then released
    task automatic press(input int n);
        restore_out <= 1'b1;
        repeat (n) @(posedge hclk);
        restore_out <= 1'b0;
    endtask
endmodule

// ### sim/camera_trigger_status_logic_tb.sv
// Self-checking bench of the trigger, exposure, restore and LED block
`include "cts_regs.vh"
module camera_trigger_status_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EXPO = 60;  // Scaled exposure length
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic        clk_en = 1'b1;
    logic [2:0]  hsize = 3'h0;
    logic        hresp;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        trig;
    logic        pin_rst;
    logic        exposure_out;
    logic        acq_start;
    logic [2:0]  led_rgb;
    logic        self_reset;
    logic [31:0] ip_addr;
    logic [31:0] q;
    int          bad_count = 0;
    int          tests_run = 0;
    int          acq_n = 0;
    int          low_n = 0;
    int          sr_n = 0;
    int          a0;
    // 125 MHz clock
    always #4 hclk = ~hclk;
    cts_top #(.BLINK_CYC(4), .RESTORE_CYC(40), .PRESS_CYC(20), .PURPLE_CYC(8)) dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_trigger_in(trig),
        .address_restore_in(pin_rst), .exposure_out(exposure_out), .acq_start(acq_start),
        .led_rgb(led_rgb), .self_reset(self_reset), .ip_addr(ip_addr));
    cts_trig_src src (.hclk(hclk), .trig_out(trig), .restore_out(pin_rst));
    // Count starts, exposure cycles and self resets
    always @(posedge hclk) begin
        acq_n <= acq_n + int'(acq_start === 1'b1);
        low_n <= low_n + int'(exposure_out === 1'b0);
        sr_n <= sr_n + int'(self_reset === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One AHB-Lite single transfer, entered just after an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        r = hrdata;
        if (n >= 50) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask
    // Set mode, send one pulse, count starts and exposure cycles
    task automatic trig_case(input logic [31:0] c, input int n);
        int a;
        int l;
        xfer(1'b1, `CTS_CTRL_OFF, c, q);
        a = acq_n;
        l = low_n;
        src.pulse();
        repeat (EXPO + 10) @(posedge hclk);
        chk("acq_count", acq_n - a, n);
        chk("expo_cycles", low_n - l, n * EXPO);
    endtask
    // Set mode and collect the colours shown over several blinks
    task automatic led_case(input logic [31:0] c, input logic [7:0] m);
        logic [7:0] s;
        s = 8'h00;
        xfer(1'b1, `CTS_CTRL_OFF, c, q);
        repeat (3) @(posedge hclk);
        repeat (16) begin
            @(posedge hclk);
            s[led_rgb] = 1'b1;
        end
        chk("led_seen", {24'h0, s}, {24'h0, m});
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        chk("expo_idle", {31'h0, exposure_out}, 32'h1);
        rdchk("ctrl_rst", `CTS_CTRL_OFF, `CTS_CTRL_RESET);
        rdchk("stat_rst", `CTS_STATUS_OFF, 32'h0);
        rdchk("expo_rst", `CTS_EXPO_OFF, `CTS_EXPO_RESET);
        rdchk("ip_rst", `CTS_IPADDR_OFF, `CTS_IP_DEFAULT);
        xfer(1'b1, 8'h10, 32'hFFFF_FFFF, q);
        rdchk("unmapped", 8'h10, 32'h0);
        xfer(1'b1, `CTS_EXPO_OFF, EXPO, q);
        trig_case(32'h1, 1);
        trig_case(32'h3, 1);
        trig_case(32'h0, 0);
        trig_case(32'h40, 1);
        // Second pulse lands inside the first exposure
        xfer(1'b1, `CTS_CTRL_OFF, 32'h1, q);
        a0 = acq_n;
        src.pulse();
        src.pulse();
        repeat (EXPO) @(posedge hclk);
        chk("drop_acq", acq_n - a0, 32'h1);
        xfer(1'b0, `CTS_STATUS_OFF, 32'h0, q);
        chk("dropped", {31'h0, q[3]}, 32'h1);
        xfer(1'b1, `CTS_STATUS_OFF, 32'h8, q);
        rdchk("drop_clr", `CTS_STATUS_OFF, 32'h0);
        led_case(32'h08, 8'h02);
        led_case(32'h18, 8'h80);
        led_case(32'h28, 8'h05);
        led_case(32'h00, 8'h03);
        // Clock enable low freezes the blinking LED
        clk_en <= 1'b0;
        repeat (2) @(posedge hclk);
        q = {29'h0, led_rgb};
        repeat (10) @(posedge hclk);
        chk("frozen_led", {29'h0, led_rgb}, q);
        clk_en <= 1'b1;
        xfer(1'b1, `CTS_IPADDR_OFF, 32'h0A00_0001, q);
        rdchk("ip_rw", `CTS_IPADDR_OFF, 32'h0A00_0001);
        src.press(50);
        repeat (4) @(posedge hclk);
        chk("ip_restored", ip_addr, `CTS_IP_DEFAULT);
        xfer(1'b0, `CTS_STATUS_OFF, 32'h0, q);
        chk("restored", {31'h0, q[1]}, 32'h1);
        a0 = sr_n;
        src.press(30);
        repeat (6) @(posedge hclk);
        chk("purple", {29'h0, led_rgb}, {29'h0, `CTS_LED_PURPLE});
        repeat (40) @(posedge hclk);
        chk("self_reset", sr_n - a0, 32'h1);
        stop_test();
    end
endmodule
